// >>> logic/hcl_loader.sv
// Configuration loader: EEPROM image reader, global config and control indirect registers
// What this block does
// [RULE1] With the read suppress bit set, no peripheral port device drives the host data bus on reads.
// [RULE2] The wavetable enable bit, from the mux control register or config byte, puts the wavetable port on the upper pins.
// [RULE3] The DSP pin select bit, from the mux control register or config byte, moves the DSP port to the lower pins.
// [RULE4] Two volume format bits in the config byte choose one of four hardware volume formats.
// [RULE5] With the decouple bit set, synthesis volume writes leave the line input volume alone.
// [RULE6] Configuration byte 8 is the code base byte; stored firmware is accepted only when it holds 0x0B.
// [RULE7] A code base byte of 0x43 makes the block ignore firmware but still load config and resource data.
// [RULE8] Control offset 3 is an index and offset 4 the data port for control indirect registers 0 to 8.
// [RULE9] The resource stream ends with tag 079H and one checksum byte.
// [RULE10] Each alternative resource set opens with tag 031H and a priority byte; the group closes with 038H.
// [RULE11] The image starts with validation bytes 055H then 0BBH, checked before any use.
// [RULE12] Two length bytes, upper first, follow the validation bytes.
// [RULE13] A failed validation skips loading and keeps the default configuration.
// [RULE14] Loaded bits apply only after the length-bounded read, and a later mux register write overrides the wavetable and DSP bits.
`timescale 1ns/10ps
`default_nettype none
`include "hcl_params.svh"

module hcl_loader
    import hcl_pkg::*;
#(
    parameter int          AW       = 16,
    parameter logic [7:0]  CHIP_ID  = 8'h5a   // Arbitrary identification value
)
(
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          ce,
    // AHB-Lite slave
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic [31:0]        hrdata,
    output logic               hresp,
    // EEPROM byte reader
    output logic               ee_req,
    output logic [AW-1:0]      ee_addr,
    input  wire logic [7:0]    ee_rdata,
    input  wire logic          ee_rvalid,
    // Peripheral port read path
    input  wire logic          periph_rd,
    output logic               periph_data_oe,
    // Pin multiplex and volume
    output logic               wavetable_port_enable,
    output logic               dsp_port_pin_select,
    output logic [1:0]         volume_format,
    output logic               synth_line_decouple,
    input  wire logic          synth_vol_we,
    input  wire logic [5:0]    synth_vol_data,
    input  wire logic          line_vol_we,
    input  wire logic [5:0]    line_vol_data,
    output logic [5:0]         line_vol,
    output logic               fw_code_accept,
    output logic               load_done
);

    if (AW < 16) begin
        $error("hcl_loader: AW must be at least 16");
    end

    hcl_load_e      lst_r;
    logic [AW-1:0]  idx_r;
    logic [15:0]    last_r;
    logic [7:0]     len_hi_r;
    logic [7:0]     gcb_shadow_r;
    logic [7:0]     code_base_r;
    logic [7:0]     gcb_r;
    logic           image_valid_r;
    logic           fw_legacy_r;
    logic           par_clear;
    logic           par_vld;
    logic           last_byte;
    logic [15:0]    last_now;
    hcl_res_s       res;

    logic [3:0]     index_r;
    logic [7:0]     cir_r [`HCL_NUM_CIR];
    logic           wr_pend_r;
    logic [5:0]     wr_reg_r;
    logic           addr_ok;
    logic [5:0]     a_reg;
    logic [3:0]     eff_index;
    logic [7:0]     cir_rd;
    logic [31:0]    rd_nxt;
    logic           mux_wr;
    hcl_stat_s      stat;

    // Loader ----------------------------------------------------------

    assign last_now  = (idx_r[15:0] == `HCL_IDX_LEN_LO) ? ({len_hi_r, ee_rdata} + 16'h0003)
                                                        : last_r;
    assign last_byte = (idx_r[15:0] >= `HCL_IDX_LEN_LO) && (idx_r[15:0] == last_now); // RULE12
    assign par_vld   = (lst_r == L_WAIT) && ee_rvalid && (idx_r[15:0] >= `HCL_IDX_RES_START);
    assign par_clear = (lst_r == L_IDLE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lst_r         <= L_IDLE;
            idx_r         <= '0;
            last_r        <= 16'h0000;
            len_hi_r      <= 8'h00;
            gcb_shadow_r  <= `HCL_GCB_RESET;
            code_base_r   <= 8'h00;
            image_valid_r <= 1'b0;
            ee_req        <= 1'b0;
            ee_addr       <= '0;
        end else if (ce) begin
            unique case (lst_r)
                L_IDLE: begin
                    idx_r <= '0;
                    lst_r <= L_REQ;
                end
                L_REQ: begin
                    ee_req  <= 1'b1;
                    ee_addr <= idx_r;
                    lst_r   <= L_WAIT;
                end
                L_WAIT: begin
                    if (ee_rvalid) begin
                        ee_req <= 1'b0;
                        idx_r  <= idx_r + AW'(1);
                        lst_r  <= L_REQ;
                        if (idx_r[15:0] == `HCL_IDX_VALID0 && ee_rdata != `HCL_VALID_BYTE0) begin
                            lst_r <= L_DONE; // RULE11 RULE13
                        end
                        if (idx_r[15:0] == `HCL_IDX_VALID1) begin
                            if (ee_rdata == `HCL_VALID_BYTE1) begin
                                image_valid_r <= 1'b1; // RULE11
                            end else begin
                                lst_r <= L_DONE; // RULE13
                            end
                        end
                        if (idx_r[15:0] == `HCL_IDX_LEN_HI) begin
                            len_hi_r <= ee_rdata; // RULE12
                        end
                        if (idx_r[15:0] == `HCL_IDX_LEN_LO) begin
                            last_r <= last_now;
                        end
                        if (idx_r[15:0] == `HCL_IDX_GCB) begin
                            gcb_shadow_r <= ee_rdata;
                        end
                        if (idx_r[15:0] == `HCL_IDX_CODE_BASE) begin
                            code_base_r <= ee_rdata; // RULE6
                        end
                        if (last_byte) begin
                            lst_r <= L_DONE; // RULE14
                        end
                    end
                end
                L_DONE: begin
                    ee_req <= 1'b0;
                end
            endcase
        end
    end

    // Firmware acceptance; only a complete valid image can grant it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fw_code_accept <= 1'b0;
            fw_legacy_r    <= 1'b0;
            load_done      <= 1'b0;
        end else if (ce) begin
            if (lst_r == L_WAIT && ee_rvalid && last_byte && image_valid_r) begin
                fw_code_accept <= (code_base_r == `HCL_CODE_OWN); // RULE6
                fw_legacy_r    <= (code_base_r == `HCL_CODE_LEGACY); // RULE7
            end
            load_done <= (lst_r == L_DONE);
        end
    end

    hcl_res_parser u_parser (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .ce       (ce),
        .clear    (par_clear),
        .byte_vld (par_vld),
        .byte_in  (ee_rdata),
        .res      (res)
    );

    // Global configuration and mux control --------------------------

    assign mux_wr = wr_pend_r && wr_reg_r == `HCL_REG_DATA && index_r == `HCL_CIR_MUX;

    // Config and resources load even for legacy firmware; only the code is dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gcb_r <= `HCL_GCB_RESET;
        end else if (ce) begin
            if (lst_r == L_WAIT && ee_rvalid && last_byte && image_valid_r) begin
                gcb_r <= gcb_shadow_r; // RULE7 RULE14
            end
        end
    end

    // Control indirect registers; the mux entry takes load, then software wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < `HCL_NUM_CIR; i++) begin
                cir_r[i] <= 8'h00;
            end
            cir_r[`HCL_CIR_MUX] <= `HCL_MUX_RESET;
        end else if (ce) begin
            if (wr_pend_r && wr_reg_r == `HCL_REG_DATA && index_r < 4'(`HCL_NUM_CIR)
                && index_r != `HCL_CIR_ID) begin
                cir_r[index_r] <= hwdata[7:0]; // RULE8 RULE14
            end
            if (lst_r == L_WAIT && ee_rvalid && last_byte && image_valid_r && !mux_wr) begin
                cir_r[`HCL_CIR_MUX][`HCL_MUX_WAVETABLE_PORT_ENABLE] <= gcb_shadow_r[`HCL_GCB_WAVETABLE_PORT_ENABLE]; // RULE14
                cir_r[`HCL_CIR_MUX][`HCL_MUX_SPS]  <= gcb_shadow_r[`HCL_GCB_SPS]; // RULE14
            end
        end
    end

    // Pin and volume outputs; one cycle behind their sources
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wavetable_port_enable <= 1'b0;
            dsp_port_pin_select   <= 1'b0;
            volume_format         <= 2'b00;
            synth_line_decouple   <= 1'b0;
            periph_data_oe        <= 1'b0;
        end else if (ce) begin
            wavetable_port_enable <= cir_r[`HCL_CIR_MUX][`HCL_MUX_WAVETABLE_PORT_ENABLE]; // RULE2
            dsp_port_pin_select   <= cir_r[`HCL_CIR_MUX][`HCL_MUX_SPS]; // RULE3
            volume_format         <= {gcb_r[`HCL_GCB_VOLUME_FORMAT_SELECT_HI], gcb_r[`HCL_GCB_VOLUME_FORMAT_SELECT_LO]}; // RULE4
            synth_line_decouple   <= gcb_r[`HCL_GCB_SYNTH_LINE_DECOUPLE];
            periph_data_oe        <= periph_rd && !gcb_r[`HCL_GCB_SDD]; // RULE1
        end
    end

    // Direct line writes win over a synthesis write in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_vol <= `HCL_LINE_VOL_RESET;
        end else if (ce) begin
            if (line_vol_we) begin
                line_vol <= line_vol_data;
            end else if (synth_vol_we && !gcb_r[`HCL_GCB_SYNTH_LINE_DECOUPLE]) begin
                line_vol <= synth_vol_data; // RULE5
            end
        end
    end

    // AHB-Lite slave --------------------------------------------------

    assign addr_ok = hsel && htrans[1] && hready;
    assign a_reg   = haddr[7:2];

    // Forward a pending index write so back-to-back index/data pairs work
    assign eff_index = (wr_pend_r && wr_reg_r == `HCL_REG_INDEX) ? hwdata[3:0] : index_r;

    always_comb begin
        cir_rd = 8'h00;
        if (eff_index == `HCL_CIR_ID) begin
            cir_rd = CHIP_ID;
        end else if (wr_pend_r && wr_reg_r == `HCL_REG_DATA) begin
            cir_rd = hwdata[7:0];
        end else if (eff_index < 4'(`HCL_NUM_CIR)) begin
            cir_rd = cir_r[eff_index]; // RULE8
        end
    end

    assign stat = '{load_done:   load_done,
                    image_valid: image_valid_r,
                    fw_accept:   fw_code_accept,
                    fw_legacy:   fw_legacy_r,
                    res:         res};

    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (haddr[31:8] == 24'h00_0000 && haddr[1:0] == 2'b00) begin
            unique case (a_reg)
                `HCL_REG_INDEX:  rd_nxt = {28'h000_0000, eff_index}; // RULE8
                `HCL_REG_DATA:   rd_nxt = {24'h00_0000, cir_rd};
                `HCL_REG_STATUS: rd_nxt = {20'h0_0000, code_base_r, 4'h0} | 32'(stat);
                `HCL_REG_GCFG:   rd_nxt = {24'h00_0000, gcb_r};
                default:         rd_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_reg_r  <= 6'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (ce) begin
            wr_pend_r <= addr_ok && hwrite && haddr[31:8] == 24'h00_0000;
            wr_reg_r  <= a_reg;
            hrdata    <= (addr_ok && !hwrite) ? rd_nxt : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            index_r <= 4'h0;
        end else if (ce) begin
            if (wr_pend_r && wr_reg_r == `HCL_REG_INDEX) begin
                index_r <= hwdata[3:0]; // RULE8
            end
        end
    end

endmodule
`default_nettype wire

// >>> shared/hcl_params.svh
// Offsets, field positions, reset values and fixed codes of the config loader
`ifndef HCL_PARAMS_SVH
`define HCL_PARAMS_SVH

`define HCL_VALID_BYTE0     8'h55
`define HCL_VALID_BYTE1     8'hbb
`define HCL_IDX_VALID0      16'h0000
`define HCL_IDX_VALID1      16'h0001
`define HCL_IDX_LEN_HI      16'h0002
`define HCL_IDX_LEN_LO      16'h0003
`define HCL_IDX_GCB         16'h0007
`define HCL_IDX_CODE_BASE   16'h0008
`define HCL_IDX_RES_START   16'h0017
`define HCL_CODE_OWN        8'h0b
`define HCL_CODE_LEGACY     8'h43
`define HCL_SERIAL_ID_LEN   4'h9
`define HCL_TAG_SET_START   8'h31
`define HCL_TAG_SET_END     8'h38
`define HCL_TAG_END         8'h79

`define HCL_REG_INDEX       6'h03
`define HCL_REG_DATA        6'h04
`define HCL_REG_STATUS      6'h05
`define HCL_REG_GCFG        6'h06
`define HCL_NUM_CIR         9
`define HCL_CIR_ID          4'h1
`define HCL_CIR_MUX         4'h8

`define HCL_GCB_SYNTH_LINE_DECOUPLE        0
`define HCL_GCB_SPS         1
`define HCL_GCB_WAVETABLE_PORT_ENABLE        2
`define HCL_GCB_VOLUME_FORMAT_SELECT_LO        3
`define HCL_GCB_VOLUME_FORMAT_SELECT_HI        4
`define HCL_GCB_SDD         5
`define HCL_MUX_SPS         1
`define HCL_MUX_WAVETABLE_PORT_ENABLE        2

`define HCL_GCB_RESET       8'h00
`define HCL_MUX_RESET       8'h00
`define HCL_LINE_VOL_RESET  6'h00

`endif

// >>> shared/hcl_pkg.sv
// Types shared by the config loader and its resource stream parser
package hcl_pkg;

    typedef enum logic [1:0] {
        L_IDLE,
        L_REQ,
        L_WAIT,
        L_DONE
    } hcl_load_e;

    typedef enum logic [2:0] {
        P_ID,
        P_TAG,
        P_LEN_LO,
        P_LEN_HI,
        P_BODY,
        P_CKSUM,
        P_DONE
    } hcl_parse_e;

    typedef struct packed {
        logic       end_seen;
        logic       checksum_ok;
        logic       fmt_err;
        logic       set_open;
        logic [3:0] set_cnt;
    } hcl_res_s;

    typedef struct packed {
        logic       load_done;
        logic       image_valid;
        logic       fw_accept;
        logic       fw_legacy;
        hcl_res_s   res;
    } hcl_stat_s;

endpackage

// >>> logic/hcl_res_parser.sv
// Walks the plug-and-play resource byte stream: sets, end tag and checksum
`timescale 1ns/10ps
`default_nettype none
`include "hcl_params.svh"

module hcl_res_parser
    import hcl_pkg::*;
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       ce,
    input  wire logic       clear,
    input  wire logic       byte_vld,
    input  wire logic [7:0] byte_in,
    output var hcl_res_s    res
);

    hcl_parse_e  st_r;
    logic [15:0] rem_r;
    logic [3:0]  id_cnt_r;
    logic [7:0]  sum_r;
    logic [7:0]  len_lo_r;
    logic [7:0]  sum_nxt;

    assign sum_nxt = sum_r + byte_in;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r     <= P_ID;
            rem_r    <= 16'h0000;
            id_cnt_r <= 4'h0;
            sum_r    <= 8'h00;
            len_lo_r <= 8'h00;
            res      <= '0;
        end else if (ce) begin
            if (clear) begin
                st_r     <= P_ID;
                id_cnt_r <= 4'h0;
                sum_r    <= 8'h00;
                res      <= '0;
            end else if (byte_vld && st_r != P_DONE) begin
                sum_r <= sum_nxt;
                unique case (st_r)
                    P_ID: begin
                        id_cnt_r <= id_cnt_r + 4'h1;
                        if (id_cnt_r == `HCL_SERIAL_ID_LEN - 4'h1) begin
                            st_r <= P_TAG;
                        end
                    end
                    P_TAG: begin
                        rem_r <= {13'h0000, byte_in[2:0]};
                        if (byte_in[7]) begin
                            st_r <= P_LEN_LO;
                        end else if (byte_in == `HCL_TAG_END) begin
                            st_r <= P_CKSUM; // RULE9
                        end else begin
                            if (byte_in == `HCL_TAG_SET_START) begin
                                res.set_open <= 1'b1; // RULE10
                                res.set_cnt  <= res.set_cnt + 4'h1;
                            end else if (byte_in[7:3] == 5'(`HCL_TAG_SET_START >> 3)) begin
                                res.fmt_err <= 1'b1; // RULE10
                            end
                            if (byte_in == `HCL_TAG_SET_END) begin
                                res.set_open <= 1'b0; // RULE10
                                if (!res.set_open) begin
                                    res.fmt_err <= 1'b1;
                                end
                            end
                            if (byte_in[2:0] != 3'h0) begin
                                st_r <= P_BODY;
                            end
                        end
                    end
                    P_LEN_LO: begin
                        len_lo_r <= byte_in;
                        st_r     <= P_LEN_HI;
                    end
                    P_LEN_HI: begin
                        rem_r <= {byte_in, len_lo_r};
                        st_r  <= ({byte_in, len_lo_r} == 16'h0000) ? P_TAG : P_BODY;
                    end
                    P_BODY: begin
                        rem_r <= rem_r - 16'h0001;
                        if (rem_r == 16'h0001) begin
                            st_r <= P_TAG;
                        end
                    end
                    P_CKSUM: begin
                        res.end_seen    <= 1'b1; // RULE9
                        res.checksum_ok <= (sum_nxt == 8'h00);
                        if (res.set_open) begin
                            res.fmt_err <= 1'b1;
                        end
                        st_r <= P_DONE;
                    end
                    P_DONE: begin
                        st_r <= P_DONE;
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// >>> testbench/hcl_loader_props.sv
// Bound checker for the configuration loader ports
`timescale 1ns/10ps
`default_nettype none
module hcl_loader_props
    import hcl_pkg::*;
#(
    parameter int         AW      = 16,
    parameter logic [7:0] CHIP_ID = 8'h5a   // Arbitrary identification value
)
(
    input wire logic          hclk,
    input wire logic          hresetn,
    input wire logic          ce,
    input wire logic          hsel,
    input wire logic [31:0]   haddr,
    input wire logic [1:0]    htrans,
    input wire logic          hwrite,
    input wire logic [2:0]    hsize,
    input wire logic [31:0]   hwdata,
    input wire logic          hready,
    input wire logic          hreadyout,
    input wire logic [31:0]   hrdata,
    input wire logic          hresp,
    input wire logic          ee_req,
    input wire logic [AW-1:0] ee_addr,
    input wire logic [7:0]    ee_rdata,
    input wire logic          ee_rvalid,
    input wire logic          periph_rd,
    input wire logic          periph_data_oe,
    input wire logic          wavetable_port_enable,
    input wire logic          dsp_port_pin_select,
    input wire logic [1:0]    volume_format,
    input wire logic          synth_line_decouple,
    input wire logic          synth_vol_we,
    input wire logic [5:0]    synth_vol_data,
    input wire logic          line_vol_we,
    input wire logic [5:0]    line_vol_data,
    input wire logic [5:0]    line_vol,
    input wire logic          fw_code_accept,
    input wire logic          load_done
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd_addr;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence s_ee_wait;
        ee_req && !ee_rvalid;
    endsequence
    sequence s_synth_only;
        synth_line_decouple && synth_vol_we && !line_vol_we;
    endsequence
    a_resp_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
        else $error("slave left zero-wait OKAY");
    a_rd_upper: assert property (s_rd_addr |=> hrdata[31:12] == 20'h0)
        else $error("read data upper bits not zero");
    a_rd_idle: assert property (hrdata != 32'h0 |-> $past(hsel && htrans[1] && !hwrite))
        else $error("read data outside a read data phase");
    a_oe_cause: assert property (periph_data_oe |-> $past(periph_rd))
        else $error("peripheral data driven without a read");
    a_fw_after_load: assert property ($rose(fw_code_accept) |-> !load_done ##1 load_done)
        else $error("firmware accepted before load end");
    a_cfg_wait: assert property (ee_req |-> volume_format == 2'b00 && !synth_line_decouple)
        else $error("config applied during image read");
    a_ee_hold: assert property (s_ee_wait |=> ee_req && $stable(ee_addr))
        else $error("byte request not held");
    a_ee_drop: assert property (ee_req && ee_rvalid |=> !ee_req)
        else $error("byte request not dropped after answer");
    a_line_direct: assert property (line_vol_we |=> line_vol == $past(line_vol_data))
        else $error("line volume write lost");
    a_synth_decouple: assert property (s_synth_only |=> $stable(line_vol))
        else $error("synthesis write changed line volume");
endmodule
bind hcl_loader hcl_loader_props #(.AW(AW), .CHIP_ID(CHIP_ID)) props_u (.*);
`default_nettype wire

// >>> testbench/hcl_ee_model.sv
// Behavioural serial EEPROM answering the loader's byte reads
`timescale 1ns/10ps
`default_nettype none
module hcl_ee_model #(
    parameter int AW = 16
)
(
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          ee_req,
    input  wire logic [AW-1:0] ee_addr,
    output logic [7:0]         ee_rdata,
    output logic               ee_rvalid
);
    logic [7:0] mem [0:255];
    logic [1:0] wait_r;
    // Data toggles outside the answer cycle so a stale byte is never taken for good
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ee_rvalid <= 1'b0;
            ee_rdata  <= 8'h00;
            wait_r    <= 2'h0;
        end else if (!ee_rvalid && ee_req && wait_r == 2'h0) begin
            ee_rvalid <= 1'b1;
            ee_rdata  <= mem[ee_addr[7:0]];
            wait_r    <= 2'($urandom % 3);
        end else begin
            ee_rvalid <= 1'b0;
            ee_rdata  <= ~ee_rdata;
            if (ee_req && wait_r != 2'h0) wait_r <= wait_r - 2'h1;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/hcl_loader_tb.sv
// Self-checking bench for the configuration loader
`timescale 1ns/10ps
`default_nettype none
`include "hcl_params.svh"
module hcl_loader_tb
    import hcl_pkg::*;
;
    logic        hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, hready;
    logic        ee_req, ee_rvalid, periph_rd, periph_data_oe, wavetable_port_enable;
    logic        dsp_port_pin_select, synth_line_decouple, synth_vol_we, line_vol_we;
    logic        fw_code_accept, load_done;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, volume_format;
    logic [2:0]  hsize;
    logic [15:0] ee_addr;
    logic [7:0]  ee_rdata, gcb, cb, sum;
    logic [5:0]  synth_vol_data, line_vol_data, line_vol;
    int          num_errors, total_checks;
    assign hready = hreadyout;
    hcl_loader dut_u (.*);
    hcl_ee_model ee_u (.*);
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_edge(input logic cond_hi, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (((cond_hi ? load_done : hreadyout) !== 1'b1) && n < lim);
        if (n >= lim) begin
            num_errors++;
            print_verdict();
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        wait_edge(1'b0, 50);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_edge(1'b0, 50);
        rd = hrdata;
    endtask
    // Builds an image, resets the loader and waits for it to finish
    task automatic load(input logic [7:0] v0, input logic [7:0] v1, input logic good);
        int p;
        for (int i = 0; i < 256; i++) ee_u.mem[i] = 8'($urandom);
        gcb = 8'($urandom) & 8'h3f;
        ee_u.mem[0] = v0;
        ee_u.mem[1] = v1;
        ee_u.mem[7] = gcb;
        ee_u.mem[8] = cb;
        p = good ? 34 : 32;
        ee_u.mem[32] = `HCL_TAG_SET_START;
        ee_u.mem[33] = 8'h00;
        ee_u.mem[p] = 8'h22;
        ee_u.mem[p+1] = 8'h20;
        ee_u.mem[p+2] = 8'h00;
        ee_u.mem[p+3] = `HCL_TAG_SET_END;
        ee_u.mem[p+4] = `HCL_TAG_END;
        sum = 8'h00;
        for (int i = 23; i < p + 5; i++) sum += ee_u.mem[i];
        ee_u.mem[p+5] = -sum;
        ee_u.mem[2] = 8'h00;
        ee_u.mem[3] = 8'(p + 2);
        hresetn <= 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        wait_edge(1'b1, 5000);
        repeat (2) @(posedge hclk);
    endtask
    task automatic check_all(input logic ok, input logic good);
        logic [7:0]  g, v;
        logic [11:0] st;
        logic [5:0]  lv;
        g = ok ? gcb : 8'h00;
        v = 8'($urandom);
        lv = 6'($urandom);
        chk(wavetable_port_enable, g[2]);
        chk(dsp_port_pin_select, g[1]);
        chk(volume_format, g[4:3]);
        chk(synth_line_decouple, g[0]);
        chk(fw_code_accept, ok && cb == 8'h0b);
        st = {1'b1, ok, ok && cb == 8'h0b, ok && cb == 8'h43, ok, ok, ok && !good, 1'b0,
              (ok && good) ? 4'h1 : 4'h0} | (ok ? {cb, 4'h0} : 12'h000);
        xfer(1'b0, 32'h14, 32'h0);
        chk(rd, {20'h0, st});
        xfer(1'b1, 32'h0c, 32'h8);
        xfer(1'b0, 32'h10, 32'h0);
        chk(rd[2:1], g[2:1]);
        xfer(1'b1, 32'h10, {24'h0, v});
        xfer(1'b1, 32'h0c, 32'h1);
        chk(wavetable_port_enable, v[2]);
        chk(dsp_port_pin_select, v[1]);
        xfer(1'b0, 32'h10, 32'h0);
        chk(rd, 32'h5a);
        xfer(1'b1, 32'h0c, 32'h9);
        xfer(1'b0, 32'h10, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, 32'h100, 32'h0);
        chk(rd, 32'h0);
        periph_rd <= 1'b1;
        repeat (2) @(posedge hclk);
        chk(periph_data_oe, !g[5]);
        periph_rd <= 1'b0;
        line_vol_data <= lv;
        line_vol_we <= 1'b1;
        @(posedge hclk);
        line_vol_we <= 1'b0;
        synth_vol_data <= ~lv;
        synth_vol_we <= 1'b1;
        @(posedge hclk);
        synth_vol_we <= 1'b0;
        repeat (2) @(posedge hclk);
        chk(line_vol, g[0] ? lv : 6'(~lv));
    endtask
    initial begin
        {hsel, hwrite, periph_rd, synth_vol_we, line_vol_we} = 5'h00;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'b00;
        hsize = 3'b010;
        synth_vol_data = 6'h00;
        line_vol_data = 6'h00;
        ce = 1'b1;
        hresetn = 1'b0;
        num_errors = 0;
        total_checks = 0;
        void'($urandom(13634));
        for (int t = 0; t < 6; t++) begin
            cb = (t == 1 || t == 4) ? 8'h43 : (t == 3 ? 8'($urandom) : 8'h0b);
            load(t == 2 ? 8'h5d : 8'h55, t == 5 ? 8'hba : 8'hbb, t != 3);
            check_all(t != 2 && t != 5, t != 3);
            $display("test %0d done errors=%0d", t, num_errors);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
